// >>> hw/jfp_mem.sv
// jfp_mem: configuration flash and user flash as one word array.
// assumes: one access per cycle; read data registered one cycle after en.
`timescale 1ns/1ps
module jfp_mem
	import jfp_pkg::*;
(
	input wire logic clk,
	jfp_mem_if.mem m
);
	// parts leave the factory erased
	logic [DW-1:0] arr [0:(2**AW)-1] = '{default: '1};

	// ------------------------------------------------------------
	// array
	// ------------------------------------------------------------

	// programming only clears bits; only erase sets them again
	always_ff @(posedge clk)
	begin
		if (m.en)
		begin
			if (m.ers)
				arr[m.addr] <= '1;
			else if (m.wr)
				arr[m.addr] <= arr[m.addr] & m.wdata;
			m.rdata <= arr[m.addr];
		end
	end
endmodule // jfp_mem

// >>> hw/jfp_mem_if.sv
// jfp_mem_if: one flash port between the controller and the flash array.
// assumes: controller drives requests; array answers one cycle later.
`timescale 1ns/1ps
interface jfp_mem_if;
	import jfp_pkg::*;
	logic en;
	logic wr;
	logic ers;
	logic [AW-1:0] addr;
	logic [DW-1:0] wdata;
	logic [DW-1:0] rdata;
	modport ctl (output en, output wr, output ers, output addr, output wdata, input rdata);
	modport mem (input en, input wr, input ers, input addr, input wdata, output rdata);
endinterface

// >>> hw/jfp_pkg.sv
// jfp_pkg: constants, encodings and state types of the test-port flash programmer.
// assumes: one 250 MHz clock (hclk); every other file but the tap driver imports this package.
package jfp_pkg;
	// ------------------------------------------------------------
	// sizes
	// ------------------------------------------------------------
	localparam int NPINS = 8; // user i/o pins under control
	localparam int AW = 8; // flash word address; msb selects user flash
	localparam int DW = 16; // flash word width
	localparam int IR_W = 10; // instruction register length
	localparam int DR_W = 32; // longest data register
	localparam int SEC_AW = 6; // words per user flash sector = 2**SEC_AW
	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int CLK_MHZ = 250;
	localparam int ERASE_MS = 500; // erase pulse per block or sector
	localparam int PROG_US = 75; // program pulse
	localparam int ERASE_CYC = ERASE_MS * 1000 * CLK_MHZ;
	localparam int PROG_CYC = PROG_US * CLK_MHZ;
	localparam int TCONFIG_CYC = 64; // configuration load interval
	// ------------------------------------------------------------
	// instruction codes
	// ------------------------------------------------------------
	localparam logic [IR_W-1:0] IR_IDCODE = 10'h016;
	localparam logic [IR_W-1:0] IR_BYPASS = 10'h3ff;
	localparam logic [IR_W-1:0] IR_ENTER = 10'h2c0;
	localparam logic [IR_W-1:0] IR_EXIT = 10'h2c1;
	localparam logic [IR_W-1:0] IR_BGENTER = 10'h2c2;
	localparam logic [IR_W-1:0] IR_CLAMP = 10'h2c3;
	localparam logic [IR_W-1:0] IR_ADDR = 10'h2c4;
	localparam logic [IR_W-1:0] IR_DATA = 10'h2c5;
	localparam logic [IR_W-1:0] IR_PROGRAM = 10'h2c6;
	localparam logic [IR_W-1:0] IR_VERIFY = 10'h2c7;
	localparam logic [IR_W-1:0] IR_ERASE_CFG = 10'h2c8;
	localparam logic [IR_W-1:0] IR_ERASE_UFM = 10'h2c9;
	localparam logic [IR_W-1:0] IR_RECONFIG = 10'h2ca;
	localparam logic [IR_W-1:0] IR_CAPTURE = 10'h001; // loaded in capture-ir
	localparam logic [31:0] IDCODE_DEF = 32'h0a5c_3001; // arbitrary value, lsb 1
	// ------------------------------------------------------------
	// flash layout (a programmed bit reads 0)
	// ------------------------------------------------------------
	localparam logic [AW-1:0] CELLS_ADDR = 8'h00; // pin enable cells
	localparam logic [AW-1:0] FLAGS_ADDR = 8'h7f; // last configuration word
	localparam logic [AW-1:0] CFG_LAST = 8'h7f;
	localparam logic [AW-1:0] UFM_BASE = 8'h80;
	localparam int FLG_DONE = 0;
	localparam int FLG_SEC = 1;
	// ------------------------------------------------------------
	// register map (byte offsets) and status fields
	// ------------------------------------------------------------
	localparam logic [7:0] REG_STATUS = 8'h00;
	localparam logic [7:0] REG_IDENT = 8'h04;
	localparam logic [7:0] REG_UFM_ADDR = 8'h08;
	localparam logic [7:0] REG_UFM_DATA = 8'h0c;
	localparam int ST_MODE = 0; // 3 bits
	localparam int ST_CLAMP = 3;
	localparam int ST_DONE = 4;
	localparam int ST_SEC = 5;
	localparam int ST_FBUSY = 6;
	localparam int ST_UBUSY = 7;
	// ------------------------------------------------------------
	// types
	// ------------------------------------------------------------
	typedef enum logic [3:0] {
		T_RESET = 4'h0, T_IDLE = 4'h1, T_SEL_DR = 4'h2, T_CAP_DR = 4'h3,
		T_SH_DR = 4'h4, T_EX1_DR = 4'h5, T_PA_DR = 4'h6, T_EX2_DR = 4'h7,
		T_UPD_DR = 4'h8, T_SEL_IR = 4'h9, T_CAP_IR = 4'ha, T_SH_IR = 4'hb,
		T_EX1_IR = 4'hc, T_PA_IR = 4'hd, T_EX2_IR = 4'he, T_UPD_IR = 4'hf
	} jfp_tap_t;
	typedef enum logic [2:0] {
		M_BOOT = 3'h0, M_USER = 3'h1, M_ISP = 3'h2, M_BG = 3'h3, M_RECFG = 3'h4
	} jfp_mode_t;
	typedef enum logic [1:0] {
		OP_NONE = 2'h0, OP_PROG = 2'h1, OP_ERS_CFG = 2'h2, OP_ERS_UFM = 2'h3
	} jfp_op_t;
	typedef enum logic [1:0] {
		RS_NONE = 2'h0, RS_JTAG = 2'h1, RS_AHB = 2'h2
	} jfp_rsrc_t;
	typedef enum logic [1:0] {
		CL_HOLD = 2'h0, CL_HIGH = 2'h1, CL_LOW = 2'h2, CL_TRI = 2'h3
	} jfp_clamp_t;
endpackage

// >>> hw/jfp_prog.sv
// jfp_prog: test-port programmer of configuration flash and user flash, with pin control.
// assumes: tck/tms/tdi arrive from pins (synchronised here); usr_* come from core logic on hclk.
`timescale 1ns/1ps
module jfp_prog
	import jfp_pkg::*;
#(
	parameter int ERASE_CYCLES = ERASE_CYC,
	parameter int PROG_CYCLES = PROG_CYC,
	parameter logic [31:0] IDCODE = IDCODE_DEF
)
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [31:0] hrdata,
	output logic hresp,
	input wire logic tck,
	input wire logic tms,
	input wire logic tdi,
	output logic tdo,
	output logic tdo_oe,
	input wire logic [jfp_pkg::NPINS-1:0] usr_out,
	input wire logic [jfp_pkg::NPINS-1:0] usr_oe,
	output logic [jfp_pkg::NPINS-1:0] io_out,
	output logic [jfp_pkg::NPINS-1:0] io_oe,
	output logic [jfp_pkg::NPINS-1:0] io_pullup,
	output logic user_run
);
	import jfp_pkg::*;

	typedef struct packed {
		logic tck_s1, tck_s2, tck_s3, tms_s1, tms_s2, tdi_s1, tdi_s2;
		jfp_tap_t tap;
		logic [IR_W-1:0] ir_sr;
		logic [IR_W-1:0] ir_q;
		logic [DR_W-1:0] dr_sr;
		logic tdo_q, tdo_oe_q;
		jfp_mode_t mode;
		logic clamp_sel;
		logic [2*NPINS-1:0] clamp_cfg;
		logic [NPINS-1:0] clamp_val, clamp_out;
		logic [AW-1:0] addr_q;
		logic [DW-1:0] wdat_q, rd_q;
		jfp_op_t op;
		logic [31:0] pcnt;
		logic sweep;
		logic [AW-1:0] swp_addr, swp_last;
		logic [7:0] boot_cnt;
		logic [NPINS-1:0] cells_q;
		logic done_q, sec_q;
		jfp_rsrc_t rd_src;
		logic a_vld, a_wr;
		logic [7:0] a_off;
		logic [AW-2:0] u_addr;
		logic [DW-1:0] u_wdat, u_rd;
		logic u_rpend, u_wpend;
		logic [31:0] hrdata_q;
		logic [NPINS-1:0] io_out_q, io_oe_q, io_pu_q;
	} jfp_st_t;

	jfp_st_t s_q, s_d;
	jfp_mem_if mif ();
	logic m_en, m_wr, m_ers;
	logic [AW-1:0] m_addr;
	logic [DW-1:0] m_wdata;
	logic rise, fall, tms_v, tdi_v, isp, busy;
	int len;

	jfp_mem u_mem (
		.clk(hclk),
		.m(mif.mem)
	);
	assign mif.en = m_en;
	assign mif.wr = m_wr;
	assign mif.ers = m_ers;
	assign mif.addr = m_addr;
	assign mif.wdata = m_wdata;

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	// standard tap walk on tms
	function automatic jfp_tap_t tap_next(input jfp_tap_t t, input logic m);
		case (t)
			T_RESET: tap_next = m ? T_RESET : T_IDLE;
			T_IDLE, T_UPD_DR, T_UPD_IR: tap_next = m ? T_SEL_DR : T_IDLE;
			T_SEL_DR: tap_next = m ? T_SEL_IR : T_CAP_DR;
			T_CAP_DR, T_SH_DR: tap_next = m ? T_EX1_DR : T_SH_DR;
			T_EX1_DR: tap_next = m ? T_UPD_DR : T_PA_DR;
			T_PA_DR: tap_next = m ? T_EX2_DR : T_PA_DR;
			T_EX2_DR: tap_next = m ? T_UPD_DR : T_SH_DR;
			T_SEL_IR: tap_next = m ? T_RESET : T_CAP_IR;
			T_CAP_IR, T_SH_IR: tap_next = m ? T_EX1_IR : T_SH_IR;
			T_EX1_IR: tap_next = m ? T_UPD_IR : T_PA_IR;
			T_PA_IR: tap_next = m ? T_EX2_IR : T_PA_IR;
			T_EX2_IR: tap_next = m ? T_UPD_IR : T_SH_IR;
			default: tap_next = T_RESET;
		endcase
	endfunction

	// data register length per instruction; unknown codes get bypass
	function automatic int dr_len(input logic [IR_W-1:0] ir);
		case (ir)
			IR_IDCODE: dr_len = 32;
			IR_ADDR: dr_len = AW;
			IR_DATA, IR_VERIFY: dr_len = DW;
			IR_CLAMP: dr_len = 2 * NPINS;
			default: dr_len = 1;
		endcase
	endfunction

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb
	begin
		s_d = s_q;
		m_en = 1'b0;
		m_wr = 1'b0;
		m_ers = 1'b0;
		m_addr = '0;
		m_wdata = '0;
		// pins pass two flops before use; tck gets a third so the edge detect can compare stages two and three
		s_d.tck_s1 = tck;
		s_d.tck_s2 = s_q.tck_s1;
		s_d.tck_s3 = s_q.tck_s2;
		s_d.tms_s1 = tms;
		s_d.tms_s2 = s_q.tms_s1;
		s_d.tdi_s1 = tdi;
		s_d.tdi_s2 = s_q.tdi_s1;
		rise = s_q.tck_s2 & ~s_q.tck_s3;
		fall = ~s_q.tck_s2 & s_q.tck_s3;
		tms_v = s_q.tms_s2;
		tdi_v = s_q.tdi_s2;
		isp = (s_q.mode == M_ISP) || (s_q.mode == M_BG);
		busy = 1'b0;
		len = dr_len(s_q.ir_q);
		s_d.rd_src = RS_NONE;

		// read data returns one cycle after the request
		if (s_q.rd_src == RS_JTAG)
			s_d.rd_q = mif.rdata;
		if (s_q.rd_src == RS_AHB)
			s_d.u_rd = mif.rdata;

		// tap on tck rising edge
		if (rise)
		begin
			case (s_q.tap)
				T_RESET: s_d.ir_q = IR_IDCODE;
				T_CAP_IR: s_d.ir_sr = IR_CAPTURE;
				T_SH_IR: s_d.ir_sr = {tdi_v, s_q.ir_sr[IR_W-1:1]};
				T_CAP_DR:
				begin
					case (s_q.ir_q)
						IR_IDCODE: s_d.dr_sr = IDCODE | 32'h0000_0001;
						IR_ADDR: s_d.dr_sr = {{(DR_W-AW){1'b0}}, s_q.addr_q};
						IR_DATA: s_d.dr_sr = {{(DR_W-DW){1'b0}}, s_q.wdat_q};
						// configuration words read as zero while secured
						IR_VERIFY: s_d.dr_sr = (s_q.sec_q && !s_q.addr_q[AW-1]) ? '0 :
							{{(DR_W-DW){1'b0}}, s_q.rd_q};
						IR_CLAMP: s_d.dr_sr = {{(DR_W-2*NPINS){1'b0}}, s_q.clamp_cfg};
						default: s_d.dr_sr = '0;
					endcase
				end
				T_SH_DR:
				begin
					s_d.dr_sr = s_q.dr_sr >> 1;
					s_d.dr_sr[len-1] = tdi_v;
				end
				T_UPD_DR:
				begin
					case (s_q.ir_q)
						IR_ADDR: s_d.addr_q = s_q.dr_sr[AW-1:0];
						IR_DATA: s_d.wdat_q = s_q.dr_sr[DW-1:0];
						IR_CLAMP:
						begin
							s_d.clamp_cfg = s_q.dr_sr[2*NPINS-1:0];
							s_d.clamp_sel = 1'b1;
						end
						default: s_d.clamp_sel = s_q.clamp_sel;
					endcase
				end
				T_UPD_IR:
				begin
					s_d.ir_q = s_q.ir_sr;
					s_d.op = OP_NONE;
					s_d.pcnt = '0;
					case (s_q.ir_sr)
						IR_ENTER:
						if (s_q.mode == M_USER)
						begin
							s_d.mode = M_ISP;
							// sample what each pin drives now
							s_d.clamp_val = s_q.io_out_q;
							s_d.clamp_out = s_q.io_oe_q;
						end
						IR_BGENTER:
						if (s_q.mode == M_USER)
							s_d.mode = M_BG;
						IR_EXIT:
						if (isp)
						begin
							s_d.mode = M_USER;
							s_d.clamp_sel = 1'b0;
						end
						IR_PROGRAM:
						if (isp)
							s_d.op = OP_PROG;
						IR_ERASE_CFG:
						if (isp)
							s_d.op = OP_ERS_CFG;
						IR_ERASE_UFM:
						if (isp)
							s_d.op = OP_ERS_UFM;
						IR_VERIFY:
						if (isp)
						begin
							// read pulse for the stored word
							m_en = 1'b1;
							m_addr = s_q.addr_q;
							s_d.rd_src = RS_JTAG;
							busy = 1'b1;
						end
						IR_RECONFIG:
						if (isp)
						begin
							s_d.mode = M_RECFG;
							s_d.boot_cnt = '0;
							s_d.clamp_sel = 1'b0;
						end
						default: s_d.op = OP_NONE;
					endcase
				end
				default: s_d.ir_q = s_q.ir_q;
			endcase
			s_d.tap = tap_next(s_q.tap, tms_v);
		end

		// tdo changes on the falling edge and drives only while shifting
		if (fall)
		begin
			s_d.tdo_q = (s_q.tap == T_SH_IR) ? s_q.ir_sr[0] : s_q.dr_sr[0];
			s_d.tdo_oe_q = (s_q.tap == T_SH_IR) || (s_q.tap == T_SH_DR);
		end

		// pulse timer counts only while idle is held; leaving idle restarts it
		if (s_q.op != OP_NONE && !s_q.sweep)
		begin
			if (s_q.tap != T_IDLE)
				s_d.pcnt = '0;
			else if (s_q.op == OP_PROG && s_q.pcnt == 32'(PROG_CYCLES - 1))
			begin
				m_en = 1'b1;
				m_wr = 1'b1;
				m_addr = s_q.addr_q;
				m_wdata = s_q.wdat_q;
				busy = 1'b1;
				s_d.op = OP_NONE;
				if (s_q.addr_q == FLAGS_ADDR && !s_q.wdat_q[FLG_SEC])
					s_d.sec_q = 1'b1;
			end
			else if (s_q.op != OP_PROG && s_q.pcnt == 32'(ERASE_CYCLES - 1))
			begin
				s_d.sweep = 1'b1;
				// configuration block whole, or one user sector
				s_d.swp_addr = (s_q.op == OP_ERS_CFG) ? '0 :
					{s_q.addr_q[AW-1:SEC_AW] | 2'b10, {SEC_AW{1'b0}}};
				s_d.swp_last = (s_q.op == OP_ERS_CFG) ? CFG_LAST :
					{s_q.addr_q[AW-1:SEC_AW] | 2'b10, {SEC_AW{1'b1}}};
			end
			else
				s_d.pcnt = s_q.pcnt + 32'h1;
		end

		// erase walk, one word per cycle
		if (s_q.sweep)
		begin
			m_en = 1'b1;
			m_ers = 1'b1;
			m_addr = s_q.swp_addr;
			busy = 1'b1;
			s_d.swp_addr = s_q.swp_addr + 8'h01;
			if (s_q.swp_addr == s_q.swp_last)
			begin
				s_d.sweep = 1'b0;
				s_d.op = OP_NONE;
				if (s_q.op == OP_ERS_CFG)
					s_d.sec_q = 1'b0;
			end
		end

		// configuration load at power-up and on reconfigure
		if (s_q.mode == M_BOOT || s_q.mode == M_RECFG)
		begin
			s_d.boot_cnt = s_q.boot_cnt + 8'h01;
			if (s_q.boot_cnt == 8'h00 || s_q.boot_cnt == 8'h01)
			begin
				m_en = 1'b1;
				m_addr = (s_q.boot_cnt == 8'h00) ? CELLS_ADDR : FLAGS_ADDR;
				busy = 1'b1;
			end
			if (s_q.boot_cnt == 8'h01)
				s_d.cells_q = mif.rdata[NPINS-1:0];
			if (s_q.boot_cnt == 8'h02)
			begin
				s_d.done_q = ~mif.rdata[FLG_DONE];
				s_d.sec_q = ~mif.rdata[FLG_SEC];
			end
			if (s_q.boot_cnt == 8'(TCONFIG_CYC - 1))
				s_d.mode = M_USER;
		end

		// bus-side user flash port takes free flash cycles
		if (!busy && (s_q.u_wpend || s_q.u_rpend))
		begin
			m_en = 1'b1;
			m_addr = {1'b1, s_q.u_addr};
			if (s_q.u_wpend)
			begin
				m_wr = 1'b1;
				m_wdata = s_q.u_wdat;
				s_d.u_wpend = 1'b0;
			end
			else
			begin
				s_d.rd_src = RS_AHB;
				s_d.u_rpend = 1'b0;
			end
		end

		// ahb data phase: register writes
		if (s_q.a_vld && s_q.a_wr)
		begin
			if (s_q.a_off == REG_UFM_ADDR)
			begin
				s_d.u_addr = hwdata[AW-2:0];
				s_d.u_rpend = 1'b1;
			end
			if (s_q.a_off == REG_UFM_DATA)
			begin
				s_d.u_wdat = hwdata[DW-1:0];
				s_d.u_wpend = 1'b1;
			end
		end

		// ahb address phase; unmapped reads return zero
		s_d.a_vld = hsel && hready && htrans[1];
		s_d.a_wr = hwrite;
		s_d.a_off = (haddr[31:4] == 28'h0) ? haddr[7:0] : 8'hff;
		// read data is loaded only by an address phase and stands until the next one
		if (s_d.a_vld)
		begin
		case (s_d.a_off)
			REG_STATUS: s_d.hrdata_q = {24'h0, s_q.u_wpend | s_q.u_rpend, s_q.op != OP_NONE,
				s_q.sec_q, s_q.done_q, s_q.clamp_sel, s_q.mode};
			REG_IDENT: s_d.hrdata_q = IDCODE | 32'h0000_0001;
			REG_UFM_ADDR: s_d.hrdata_q = {{(33-AW){1'b0}}, s_q.u_addr};
			REG_UFM_DATA: s_d.hrdata_q = {{(32-DW){1'b0}}, s_q.u_rd};
			default: s_d.hrdata_q = 32'h0;
		endcase
		end

		// pin control, registered so mode changes cannot glitch the pads
		for (int i = 0; i < NPINS; i++)
		begin
			s_d.io_out_q[i] = 1'b0;
			s_d.io_oe_q[i] = 1'b0;
			s_d.io_pu_q[i] = 1'b1;
			if (s_q.mode == M_USER || s_q.mode == M_BG)
			begin
				s_d.io_out_q[i] = usr_out[i];
				s_d.io_oe_q[i] = usr_oe[i] & s_q.cells_q[i] & s_q.done_q;
				s_d.io_pu_q[i] = 1'b0;
			end
			else if (s_q.mode == M_ISP && s_q.clamp_sel)
			begin
				case (jfp_clamp_t'(s_q.clamp_cfg[2*i +: 2]))
					CL_HOLD:
					begin
						s_d.io_out_q[i] = s_q.clamp_val[i];
						s_d.io_oe_q[i] = s_q.clamp_out[i];
					end
					CL_HIGH:
					begin
						s_d.io_out_q[i] = 1'b1;
						s_d.io_oe_q[i] = 1'b1;
					end
					CL_LOW: s_d.io_oe_q[i] = 1'b1;
					default: s_d.io_oe_q[i] = 1'b0;
				endcase
				s_d.io_pu_q[i] = ~s_d.io_oe_q[i];
			end
		end
	end

	// ------------------------------------------------------------
	// state register
	// ------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			s_q <= '0;
			s_q.tap <= T_RESET;
			s_q.ir_q <= IR_IDCODE;
			s_q.mode <= M_BOOT;
			s_q.io_pu_q <= '1;
		end
		else
			s_q <= s_d;
	end

	// outputs
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = s_q.hrdata_q;
	assign tdo = s_q.tdo_q;
	assign tdo_oe = s_q.tdo_oe_q;
	assign io_out = s_q.io_out_q;
	assign io_oe = s_q.io_oe_q;
	assign io_pullup = s_q.io_pu_q;
	assign user_run = (s_q.mode == M_USER) || (s_q.mode == M_BG);
endmodule // jfp_prog

// >>> sim/jfp_prog_asserts.sv
// jfp_prog_asserts: port-level checks of the test-port flash programmer.
// assumes: bound into jfp_prog; the bench ties hready to hreadyout.
`timescale 1ns/1ps
module jfp_prog_asserts
	import jfp_pkg::*;
#(
	parameter logic [31:0] IDCODE = IDCODE_DEF
)
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic [31:0] hrdata,
	input wire logic hresp,
	input wire logic tck,
	input wire logic tdo,
	input wire logic tdo_oe,
	input wire logic [jfp_pkg::NPINS-1:0] io_oe,
	input wire logic [jfp_pkg::NPINS-1:0] io_pullup,
	input wire logic user_run
);
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	// cycles since reset release, saturating
	logic [7:0] cyc_q;
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			cyc_q <= 8'h00;
		else if (cyc_q != 8'hff)
			cyc_q <= cyc_q + 8'h01;
	end
	// read address phase taken at one offset
	sequence rd_taken(logic [7:0] a);
		hsel && hready && htrans[1] && !hwrite && haddr[7:0] == a;
	endsequence
	// ----------------------------------------
	// assertions
	// ----------------------------------------
	bus_okay_a: assert property (hreadyout && !hresp)
		else $error("bus answer not ready or not okay");
	hrdata_hold_a: assert property (!(hsel && hready && htrans[1]) |=> $stable(hrdata))
		else $error("read data moved without a transfer");
	ident_read_a: assert property (rd_taken(8'h04) |=> hrdata == {IDCODE[31:1], 1'b1})
		else $error("identifier read wrong");
	unmapped_zero_a: assert property (hsel && hready && htrans[1] && !hwrite && haddr[7:0] >= 8'h10 |=> hrdata == 32'h0)
		else $error("unmapped read not zero");
	tdo_fall_a: assert property ($changed(tdo) |-> !tck && !$past(tck))
		else $error("tdo moved outside the low tck phase");
	tdo_oe_edge_a: assert property ($changed(tdo_oe) |-> !tck && !$past(tck))
		else $error("tdo enable moved outside the low tck phase");
	boot_quiet_a: assert property (cyc_q < 8'd60 |-> io_oe == '0 && io_pullup == '1 && !user_run)
		else $error("pins or core active during power-up load");
	boot_done_a: assert property (cyc_q == 8'd90 |-> user_run)
		else $error("core not running after power-up load");
endmodule // jfp_prog_asserts

bind jfp_prog jfp_prog_asserts #(.IDCODE(IDCODE)) u_jfp_prog_asserts (.*);

// >>> sim/jfp_prog_bench.sv
// jfp_prog_bench: self-checking bench of the test-port flash programmer.
// assumes: jfp_tap_drv plays the external programmer; the bench is the only bus master.
`timescale 1ns/1ps
module jfp_prog_bench;
	import jfp_pkg::*;
	localparam int EC = 200;
	localparam int PC = 50;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic [7:0] usr_out = 8'h00;
	logic [7:0] usr_oe = 8'h00;
	logic hreadyout, hresp, tck, tms, tdi, tdo, tdo_oe, user_run;
	logic [31:0] hrdata, r, o;
	logic [7:0] io_out, io_oe, io_pullup, ca, ua;
	logic [15:0] cd, ud;
	logic off_q = 1'b0;
	logic clamp_on = 1'b0;
	logic [7:0] x_out, x_oe;
	int num_errors = 0;
	int n_compared = 0;
	always #2 hclk = ~hclk;
	jfp_prog #(.ERASE_CYCLES(EC), .PROG_CYCLES(PC)) u_jfp_prog (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
		.tdo_oe(tdo_oe), .usr_out(usr_out), .usr_oe(usr_oe), .io_out(io_out), .io_oe(io_oe),
		.io_pullup(io_pullup), .user_run(user_run));
	jfp_tap_drv u_jfp_tap_drv (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));
	// ----------------------------------------
	// checking and bus tasks
	// ----------------------------------------
	task automatic finish_test();
		$display("compared %0d errors %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			num_errors++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic bad();
		num_errors++;
		$display("[ERR] %0t wait ran out", $time);
		finish_test();
	endtask
	// expected status low bits from mode, completion flag and security
	function automatic logic [31:0] st_exp(logic [2:0] m, logic d, logic s);
		return {26'h0, s, d, 1'b0, m};
	endfunction
	// next edge, then bounded wait for hready
	task automatic rdy();
		@(posedge hclk);
		for (int k = 0; hreadyout !== 1'b1; k++)
		begin
			if (k == 16)
				bad();
			@(posedge hclk);
		end
	endtask
	task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h0, a};
		rdy();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		rdy();
		rd = hrdata;
	endtask
	// ----------------------------------------
	// test-port operations
	// ----------------------------------------
	// only defined instruction codes are ever loaded
	task automatic op(input logic [9:0] c, input int n, input logic [31:0] d);
		u_jfp_tap_drv.scan(1'b1, IR_W, {22'h0, c}, o);
		chk(o & 32'h3ff, {22'h0, IR_CAPTURE});
		if (n > 0)
			u_jfp_tap_drv.scan(1'b0, n, d, o);
	endtask
	task automatic prog(input logic [7:0] a, input logic [15:0] d);
		op(IR_ADDR, AW, {24'h0, a});
		op(IR_DATA, DW, {16'h0, d});
		op(IR_PROGRAM, 0, 32'h0);
		repeat (PC + 20) @(posedge hclk);
	endtask
	task automatic erase(input logic [9:0] c, input logic [7:0] a);
		op(IR_ADDR, AW, {24'h0, a});
		op(c, 0, 32'h0);
		repeat (EC + 160) @(posedge hclk);
	endtask
	task automatic vchk(input logic [7:0] a, input logic [15:0] e);
		op(IR_ADDR, AW, {24'h0, a});
		op(IR_VERIFY, DW, 32'h0);
		chk(o & 32'hffff, {16'h0, e});
		if ((o & 32'hffff) !== {16'h0, e}) finish_test();
	endtask
	// while the core design is stopped and no clamp is set, pins stay released with pull-ups
	always @(posedge hclk)
	begin
		if (off_q && !clamp_on && user_run === 1'b0 && (io_oe !== 8'h00 || io_pullup !== 8'hff))
		begin
			num_errors++;
			$display("[ERR] %0t pins driven while stopped", $time);
		end
		off_q <= hresetn && user_run === 1'b0;
	end
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial
	begin
		void'($urandom(45255));
		ca = 8'($urandom_range(126, 1));
		ua = 8'($urandom_range(255, 128));
		cd = 16'($urandom);
		ud = 16'($urandom);
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		usr_out <= 8'($urandom);
		usr_oe <= 8'($urandom);
		repeat (100) @(posedge hclk);
		ahb(1'b0, REG_STATUS, 32'h0, r);
		chk(r & 32'h3f, st_exp(M_USER, 1'b0, 1'b0));
		chk({24'h0, io_oe}, 32'h0);
		ahb(1'b0, REG_IDENT, 32'h0, r);
		chk(r, IDCODE_DEF);
		ahb(1'b0, 8'h20, 32'h0, r);
		chk(r, 32'h0);
		u_jfp_tap_drv.treset();
		op(IR_IDCODE, DR_W, 32'h0);
		chk(o, IDCODE_DEF);
		if (o !== IDCODE_DEF) finish_test();
		op(IR_ENTER, 0, 32'h0);
		chk({15'h0, user_run, io_oe, io_pullup}, {15'h0, 1'b0, 8'h00, 8'hff});
		erase(IR_ERASE_CFG, 8'h00);
		prog(ca, cd);
		prog(ua, ud);
		vchk(ca, cd);
		erase(IR_ERASE_UFM, ua);
		vchk(ua, 16'hffff);
		vchk(ca, cd);
		prog(FLAGS_ADDR, 16'hfffc);
		vchk(ca, 16'h0000);
		prog(ua, ud);
		vchk(ua, ud);
		ahb(1'b1, REG_UFM_ADDR, {25'h0, ua[6:0]}, r);
		r = 32'h80;
		for (int k = 0; r[7] !== 1'b0; k++)
		begin
			if (k == 20)
				bad();
			ahb(1'b0, REG_STATUS, 32'h0, r);
		end
		chk(r & 32'h3f, st_exp(M_ISP, 1'b0, 1'b1));
		ahb(1'b0, REG_UFM_DATA, 32'h0, r);
		chk(r & 32'hffff, {16'h0, ud});
		op(IR_RECONFIG, 0, 32'h0);
		repeat (120) @(posedge hclk);
		ahb(1'b0, REG_STATUS, 32'h0, r);
		chk(r & 32'h3f, st_exp(M_USER, 1'b1, 1'b1));
		chk({16'h0, io_out, io_oe}, {16'h0, usr_out, usr_oe});
		op(IR_BGENTER, 0, 32'h0);
		chk({31'h0, user_run}, 32'h1);
		erase(IR_ERASE_CFG, 8'h00);
		vchk(ca, 16'hffff);
		op(IR_EXIT, 0, 32'h0);
		ahb(1'b0, REG_STATUS, 32'h0, r);
		chk(r & 32'h17, 32'h11);
		// clamp per pin group: hold, high, low, tri
		op(IR_CLAMP, 2 * NPINS, 32'h0000_e4e4);
		clamp_on = 1'b1;
		op(IR_ENTER, 0, 32'h0);
		x_oe = (usr_oe & 8'h11) | 8'h66;
		x_out = (usr_out & 8'h11) | 8'h22;
		chk({8'h0, io_out, io_oe, io_pullup}, {8'h0, x_out, x_oe, ~x_oe});
		vchk(ua, ud);
		op(IR_EXIT, 0, 32'h0);
		clamp_on = 1'b0;
		chk({31'h0, user_run}, 32'h1);
		finish_test();
	end
endmodule // jfp_prog_bench

// >>> sim/jfp_tap_drv.sv
// jfp_tap_drv: behavioural external programmer on the four test-port pins.
// assumes: tck stands low between scans; tdo is taken just before each rising tck.
`timescale 1ns/1ps
module jfp_tap_drv
(
	output logic tck,
	output logic tms,
	output logic tdi,
	input wire logic tdo
);
	// idle pin levels at time zero
	initial
	begin
		tck = 1'b0;
		tms = 1'b1;
		tdi = 1'b0;
	end
	// one 160 ns tck period; only the four pins carry traffic
	task automatic step(input logic m, input logic d, output logic o);
		#1;
		tms = m;
		tdi = d;
		#79;
		o = tdo;
		tck = 1'b1;
		#80;
		tck = 1'b0;
	endtask
	// five ones reach test-logic-reset, then park in run-test/idle
	task automatic treset();
		logic o;
		repeat (5) step(1'b1, ~tdi, o);
		step(1'b0, ~tdi, o);
	endtask
	// scan n bits lsb first through ir or dr, back to run-test/idle
	task automatic scan(input logic ir, input int n, input logic [31:0] din, output logic [31:0] dout);
		logic o;
		dout = 32'h0;
		step(1'b1, ~tdi, o);
		if (ir)
			step(1'b1, ~tdi, o);
		step(1'b0, ~tdi, o);
		step(1'b0, ~tdi, o);
		for (int i = 0; i < n; i++)
		begin
			step(i == n - 1, din[i], o);
			dout[i] = o;
		end
		step(1'b1, ~tdi, o);
		step(1'b0, ~tdi, o);
	endtask
endmodule // jfp_tap_drv
